// *** hw/cfrbd_conditioner.sv ***
// conditions the comparator and charge-enable pins
`timescale 1ns/1ns
module cfrbd_conditioner
  import cfrbd_pkg::*;
(
  // clock and reset
  input  wire logic    mclk_in,
  input  wire logic    reset_in,
  // raw pins
  input  wire logic    above_recharge_in,
  input  wire logic    below_short_in,
  input  wire logic    over_limit_in,
  input  wire logic    charge_enable_n_in,
  // clean levels
  cfrbd_cmp_if.source  cmp
);

  logic en_prev_q;

  cfrbd_debounce u_rch (.mclk_in(mclk_in), .reset_in(reset_in), .pin_in(above_recharge_in),
                        .init_in(1'b0), .level_out(cmp.above_recharge));
  cfrbd_debounce u_sc  (.mclk_in(mclk_in), .reset_in(reset_in), .pin_in(below_short_in),
                        .init_in(1'b0), .level_out(cmp.below_short));
  cfrbd_debounce u_ov  (.mclk_in(mclk_in), .reset_in(reset_in), .pin_in(over_limit_in),
                        .init_in(1'b0), .level_out(cmp.over_limit));
  cfrbd_debounce u_en  (.mclk_in(mclk_in), .reset_in(reset_in), .pin_in(charge_enable_n_in),
                        .init_in(1'b1), .level_out(cmp.enable_n));

  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
      en_prev_q <= 1'b1;
    else
      en_prev_q <= cmp.enable_n;
  end

  // high-to-low edge of the clean enable
  assign cmp.enable_fall = en_prev_q & ~cmp.enable_n;

endmodule : cfrbd_conditioner

// *** hw/cfrbd_debounce.sv ***
// three-flop synchroniser and stability filter for one pin
`timescale 1ns/1ns
module cfrbd_debounce
  import cfrbd_pkg::*;
(
  // clock and reset
  input  wire logic mclk_in,
  input  wire logic reset_in,
  // pin and clean level
  input  wire logic pin_in,
  input  wire logic init_in,
  output logic      level_out
);

  logic                 s1_q, s2_q, s3_q;
  logic                 s1_d, s2_d, s3_d;
  logic [DEB_W-1:0]     cnt_q, cnt_d;
  logic                 lvl_q, lvl_d;
  logic                 init_q;

  // idle level shows until the first clock, so no false enable edge
  assign level_out = init_q ? lvl_q : init_in;

  always_comb
  begin
    s1_d  = pin_in;
    s2_d  = s1_q;
    s3_d  = s2_q;
    cnt_d = cnt_q;
    lvl_d = lvl_q;
    // change counts once stage two and three agree, then must hold
    if (s2_q != s3_q || s3_q == lvl_q)
      cnt_d = '0;
    else if (cnt_q == DEB_W'(DEBOUNCE_CYCLES - 1))
    begin
      lvl_d = s3_q;
      cnt_d = '0;
    end
    else
      cnt_d = cnt_q + DEB_W'(1);
    // first clock after reset loads the pin's idle level
    if (!init_q)
      lvl_d = init_in;
  end

  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      s1_q   <= 1'b0;
      s2_q   <= 1'b0;
      s3_q   <= 1'b0;
      cnt_q  <= '0;
      lvl_q  <= 1'b0;
      init_q <= 1'b0;
    end
    else
    begin
      s1_q   <= s1_d;
      s2_q   <= s2_d;
      s3_q   <= s3_d;
      cnt_q  <= cnt_d;
      init_q <= 1'b1;
      lvl_q  <= lvl_d;
    end
  end

endmodule : cfrbd_debounce

// *** hw/cfrbd_sequencer.sv ***
// charge fault recovery and battery-absent detection sequencer
// Contract
// - fault above recharge level waits for a fall below it, then runs detection
// - power-on reset or enable toggle clears a timer fault at any voltage
// - fault below recharge level turns on the removal probe current
// - probe switched off when voltage rises above recharge; then high-fault path
// - overvoltage stops the converter and both status outputs at once
// - overvoltage fault clears when voltage is down to recharge level, or on an enable toggle
// - fall to recharge level after fast charge starts the detection test
// - discharge sink for a fixed time, then sample below short threshold
// - wake current for a fixed time, then sample above recharge threshold
// - both checks pass: report battery absent on status outputs
// - either check fails: start a new charge cycle
// - crossing recharge while charging ends charge, enables removal sink
// - timer faults blink first status at slow rate, second stays off
// - enable falling edge resets timers and faults; high level stops charging
`timescale 1ns/1ns
module cfrbd_sequencer
  import cfrbd_pkg::*;
#(
  parameter cfrbd_count_t SINK_CYC    = cfrbd_count_t'(SINK_CYCLES),
  parameter cfrbd_count_t WAKE_CYC    = cfrbd_count_t'(WAKE_CYCLES),
  parameter cfrbd_count_t REMOVAL_CYC = cfrbd_count_t'(REMOVAL_CYCLES),
  parameter cfrbd_count_t BLINK_CYC   = cfrbd_count_t'(BLINK_HALF_CYCLES)
)
(
  // clock and reset
  input  wire logic mclk_in,
  input  wire logic reset_in,
  // comparator pins
  input  wire logic above_recharge_in,
  input  wire logic below_short_in,
  input  wire logic over_limit_in,
  // control
  input  wire logic charge_enable_n_in,
  input  wire logic timer_fault_in,
  input  wire logic charge_done_in,
  // converter and current sources
  output logic      pwm_enable_out,
  output logic      probe_current_out,
  output logic      absent_test_sink_out,
  output logic      wake_current_out,
  output logic      removal_sink_out,
  // status, open-drain, enable low means pin pulled on
  output logic      status_output_first_oe_n_out,
  output logic      status_output_second_oe_n_out,
  output logic      timer_fault_flag_out,
  output logic      absent_flag_out
);

  // =====================================================================
  // conditioning
  // =====================================================================
  cfrbd_cmp_if cmp ();

  cfrbd_conditioner u_cond
  (
    .mclk_in            (mclk_in),
    .reset_in           (reset_in),
    .above_recharge_in  (above_recharge_in),
    .below_short_in     (below_short_in),
    .over_limit_in      (over_limit_in),
    .charge_enable_n_in (charge_enable_n_in),
    .cmp                (cmp.source)
  );

  // =====================================================================
  // state and timers
  // =====================================================================
  cfrbd_state_e state_q, state_d;
  cfrbd_count_t tmr_q, tmr_d;
  cfrbd_count_t blk_q, blk_d;
  logic         blink_q, blink_d;
  logic         sink_ok_q, sink_ok_d;
  logic         pwm_q, pwm_d;
  logic         probe_q, probe_d;
  logic         sink_q, sink_d;
  logic         wake_q, wake_d;
  logic         rem_q, rem_d;
  logic         st1_q, st1_d;
  logic         st2_q, st2_d;
  logic         tflt_q, tflt_d;
  logic         abs_q, abs_d;

  function automatic logic expired(input cfrbd_count_t t, input cfrbd_count_t lim);
    expired = (t >= lim - cfrbd_count_t'(1));
  endfunction : expired

  // both timer fault states drive the same flag and blink
  function automatic logic in_fault(input cfrbd_state_e s);
    in_fault = (s == ST_FLT_LOW) || (s == ST_FLT_HIGH);
  endfunction : in_fault

  always_comb
  begin
    state_d   = state_q;
    tmr_d     = tmr_q + cfrbd_count_t'(1);
    sink_ok_d = sink_ok_q;
    case (state_q)
      ST_IDLE:
      begin
        tmr_d = '0;
        if (!cmp.enable_n)
          state_d = ST_CHARGE;
      end
      ST_CHARGE:
      begin
        if (timer_fault_in)
          state_d = cmp.above_recharge ? ST_FLT_HIGH : ST_FLT_LOW;
        else if (charge_done_in)
          state_d = ST_DONE;
        else if (cmp.above_recharge)
        begin
          state_d = ST_REMOVAL;
          tmr_d   = '0;
        end
      end
      ST_REMOVAL:
        if (expired(tmr_q, REMOVAL_CYC))
        begin
          state_d = cmp.above_recharge ? ST_DONE : ST_SINK;
          tmr_d   = '0;
        end
      ST_DONE:
        if (!cmp.above_recharge)
        begin
          state_d = ST_SINK;
          tmr_d   = '0;
        end
      ST_SINK:
        if (expired(tmr_q, SINK_CYC))
        begin
          sink_ok_d = cmp.below_short;
          state_d   = ST_WAKE;
          tmr_d     = '0;
        end
      ST_WAKE:
        if (expired(tmr_q, WAKE_CYC))
        begin
          if (sink_ok_q && cmp.above_recharge)
            state_d = ST_ABSENT;
          else
            state_d = ST_CHARGE;
          tmr_d = '0;
        end
      ST_ABSENT:
        if (!cmp.above_recharge)
        begin
          state_d = ST_SINK;
          tmr_d   = '0;
        end
      ST_FLT_LOW:
        if (cmp.above_recharge)
          state_d = ST_FLT_HIGH;
      ST_FLT_HIGH:
        if (!cmp.above_recharge)
        begin
          state_d = ST_SINK;
          tmr_d   = '0;
        end
      ST_OVP:
        if (!cmp.above_recharge)
        begin
          state_d = ST_SINK;
          tmr_d   = '0;
        end
      default:
        state_d = ST_IDLE;
    endcase

    // overvoltage beats everything except enable
    if (cmp.over_limit)
      state_d = ST_OVP;
    if (cmp.enable_n)
      state_d = ST_IDLE;
    else if (cmp.enable_fall)
    begin
      state_d = ST_CHARGE;
      tmr_d   = '0;
    end
  end

  // =====================================================================
  // state register
  // =====================================================================
  // phase timer counts up every cycle outside ST_IDLE, where it holds zero; sink result changes only with the state
  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      state_q   <= ST_IDLE;
      tmr_q     <= '0;
      sink_ok_q <= 1'b0;
    end
    else
    begin
      state_q   <= state_d;
      tmr_q     <= tmr_d;
      sink_ok_q <= sink_ok_d;
    end
  end

  // =====================================================================
  // slow blink divider for fault indication
  // =====================================================================
  // free-running, so a fault starts blinking in whatever phase it finds
  // one toggle per BLINK_CYC cycles gives the slow on/off rate
  always_comb
  begin
    blk_d   = blk_q + cfrbd_count_t'(1);
    blink_d = blink_q;
    if (expired(blk_q, BLINK_CYC))
    begin
      blk_d   = '0;
      blink_d = ~blink_q;
    end
  end

  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      blk_q   <= '0;
      blink_q <= 1'b0;
    end
    else
    begin
      blk_q   <= blk_d;
      blink_q <= blink_d;
    end
  end

  // =====================================================================
  // output flops, decoded from the next state
  // =====================================================================
  // currents and flags follow the next state, so they change with it
  // status flops hold the pin enables: low pulls the pin on
  always_comb
  begin
    pwm_d   = (state_d == ST_CHARGE);
    probe_d = (state_d == ST_FLT_LOW);
    sink_d  = (state_d == ST_SINK);
    wake_d  = (state_d == ST_WAKE);
    rem_d   = (state_d == ST_REMOVAL);
    tflt_d  = in_fault(state_d);
    abs_d   = (state_d == ST_ABSENT);
    st2_d   = (state_d != ST_DONE);
    if (state_d == ST_CHARGE)
      st1_d = 1'b0;
    else if (in_fault(state_d))
      st1_d = ~blink_d;
    else
      st1_d = 1'b1;
  end

  // pins start released, all sources off
  always_ff @(posedge mclk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      pwm_q   <= RST_PWM_EN;
      probe_q <= 1'b0;
      sink_q  <= 1'b0;
      wake_q  <= 1'b0;
      rem_q   <= 1'b0;
      st1_q   <= ~RST_STATUS;
      st2_q   <= ~RST_STATUS;
      tflt_q  <= 1'b0;
      abs_q   <= 1'b0;
    end
    else
    begin
      pwm_q   <= pwm_d;
      probe_q <= probe_d;
      sink_q  <= sink_d;
      wake_q  <= wake_d;
      rem_q   <= rem_d;
      st1_q   <= st1_d;
      st2_q   <= st2_d;
      tflt_q  <= tflt_d;
      abs_q   <= abs_d;
    end
  end

  // =====================================================================
  // outputs
  // =====================================================================
  assign pwm_enable_out                = pwm_q;
  assign probe_current_out             = probe_q;
  assign absent_test_sink_out          = sink_q;
  assign wake_current_out              = wake_q;
  assign removal_sink_out              = rem_q;
  assign status_output_first_oe_n_out  = st1_q;
  assign status_output_second_oe_n_out = st2_q;
  assign timer_fault_flag_out          = tflt_q;
  assign absent_flag_out               = abs_q;

endmodule : cfrbd_sequencer

// *** include/cfrbd_cmp_if.sv ***
// clean comparator levels passed from the conditioner to the sequencer
`timescale 1ns/1ns
interface cfrbd_cmp_if;
  logic above_recharge;
  logic below_short;
  logic over_limit;
  logic enable_n;
  logic enable_fall;

  modport source (output above_recharge, below_short, over_limit, enable_n, enable_fall);
  modport sink   (input  above_recharge, below_short, over_limit, enable_n, enable_fall);
endinterface : cfrbd_cmp_if

// *** include/cfrbd_pkg.sv ***
// constants and types shared by the charge fault recovery sequencer
package cfrbd_pkg;

  // =====================================================================
  // timing
  // =====================================================================
  localparam int unsigned CLK_HZ            = 250_000_000;
  localparam int unsigned CLK_PERIOD_NS     = 4;
  localparam int unsigned SINK_TIME_MS      = 1000;
  localparam int unsigned WAKE_TIME_MS      = 500;
  localparam int unsigned REMOVAL_TIME_MS   = 1000;
  localparam int unsigned BLINK_HALF_MS     = 1000;
  localparam int unsigned DEBOUNCE_NS       = 1000;
  localparam int unsigned MS_CYCLES         = CLK_HZ / 1000;
  localparam int unsigned SINK_CYCLES       = SINK_TIME_MS * MS_CYCLES;
  localparam int unsigned WAKE_CYCLES       = WAKE_TIME_MS * MS_CYCLES;
  localparam int unsigned REMOVAL_CYCLES    = REMOVAL_TIME_MS * MS_CYCLES;
  localparam int unsigned BLINK_HALF_CYCLES = BLINK_HALF_MS * MS_CYCLES;
  localparam int unsigned DEBOUNCE_CYCLES   = DEBOUNCE_NS / CLK_PERIOD_NS;
  localparam int unsigned TIMER_W           = 32;
  localparam int unsigned DEB_W             = 8;

  // =====================================================================
  // reset values
  // =====================================================================
  localparam logic        RST_STATUS        = 1'b0;
  localparam logic        RST_PWM_EN        = 1'b0;

  // =====================================================================
  // types
  // =====================================================================
  typedef logic [TIMER_W-1:0] cfrbd_count_t;

  typedef enum logic [3:0]
  {
    ST_IDLE      = 4'h0,
    ST_CHARGE    = 4'h1,
    ST_DONE      = 4'h3,
    ST_SINK      = 4'h2,
    ST_WAKE      = 4'h6,
    ST_ABSENT    = 4'h7,
    ST_REMOVAL   = 4'h5,
    ST_FLT_HIGH  = 4'h4,
    ST_FLT_LOW   = 4'hc,
    ST_OVP       = 4'hd
  } cfrbd_state_e;

endpackage : cfrbd_pkg

// *** sim/cfrbd_assertions.sv ***
// port checker for the charge fault recovery sequencer
`timescale 1ns/1ns
module cfrbd_assertions
  import cfrbd_pkg::*;
#(
  parameter cfrbd_count_t SINK_CYC    = 32'h190,
  parameter cfrbd_count_t WAKE_CYC    = 32'h190,
  parameter cfrbd_count_t REMOVAL_CYC = 32'h12c,
  parameter cfrbd_count_t BLINK_CYC   = 32'h12c
)
(
  // clock and reset
  input wire logic mclk_in,
  input wire logic reset_in,
  // watched outputs
  input wire logic pwm_enable_out,
  input wire logic probe_current_out,
  input wire logic absent_test_sink_out,
  input wire logic wake_current_out,
  input wire logic removal_sink_out,
  input wire logic status_output_first_oe_n_out,
  input wire logic status_output_second_oe_n_out,
  input wire logic timer_fault_flag_out,
  input wire logic absent_flag_out
);
  import cfrbd_pkg::*;
  cfrbd_count_t sink_n_q;
  cfrbd_count_t wake_n_q;
  cfrbd_count_t rem_n_q;
  // =====================================================================
  // phase length counters
  // =====================================================================
  always_ff @(posedge mclk_in or posedge reset_in)
    if (reset_in)
    begin
      sink_n_q <= '0;
      wake_n_q <= '0;
      rem_n_q  <= '0;
    end
    else
    begin
      sink_n_q <= absent_test_sink_out ? sink_n_q + 32'h1 : '0;
      wake_n_q <= wake_current_out ? wake_n_q + 32'h1 : '0;
      rem_n_q  <= removal_sink_out ? rem_n_q + 32'h1 : '0;
    end
  // =====================================================================
  // properties
  // =====================================================================
  default clocking @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  sink_length_a: assert property ($fell(absent_test_sink_out) |-> sink_n_q == SINK_CYC)
    else $error("sink phase length wrong");
  wake_length_a: assert property ($fell(wake_current_out) |-> wake_n_q == WAKE_CYC)
    else $error("wake phase length wrong");
  removal_length_a: assert property ($fell(removal_sink_out) |-> rem_n_q == REMOVAL_CYC)
    else $error("removal sink length wrong");
  wake_follows_a: assert property ($rose(wake_current_out) |-> $past(absent_test_sink_out))
    else $error("wake without sink before it");
  check_result_a: assert property ($fell(wake_current_out) |-> absent_flag_out || pwm_enable_out)
    else $error("no outcome after wake phase");
  absent_dark_a: assert property (absent_flag_out |-> status_output_first_oe_n_out
    && status_output_second_oe_n_out && !pwm_enable_out)
    else $error("absent report not dark");
  probe_fault_a: assert property (probe_current_out |-> timer_fault_flag_out && !pwm_enable_out)
    else $error("probe on outside fault");
  fault_second_a: assert property (timer_fault_flag_out |-> status_output_second_oe_n_out)
    else $error("second status on in fault");
  sink_alone_a: assert property (absent_test_sink_out |-> !wake_current_out && !pwm_enable_out)
    else $error("sink overlaps other drive");
  absent_cov: cover property ($rose(absent_flag_out));
  fault_cov: cover property ($rose(probe_current_out));
  removal_cov: cover property ($rose(removal_sink_out));
endmodule : cfrbd_assertions

// *** sim/cfrbd_bench.sv ***
// self-checking bench for the charge fault recovery sequencer
`timescale 1ns/1ns
bind cfrbd_sequencer cfrbd_assertions #(.SINK_CYC(SINK_CYC), .WAKE_CYC(WAKE_CYC),
  .REMOVAL_CYC(REMOVAL_CYC), .BLINK_CYC(BLINK_CYC)) chk (.mclk_in(mclk_in),
  .reset_in(reset_in), .pwm_enable_out(pwm_enable_out), .probe_current_out(probe_current_out),
  .absent_test_sink_out(absent_test_sink_out), .wake_current_out(wake_current_out),
  .removal_sink_out(removal_sink_out),
  .status_output_first_oe_n_out(status_output_first_oe_n_out),
  .status_output_second_oe_n_out(status_output_second_oe_n_out),
  .timer_fault_flag_out(timer_fault_flag_out), .absent_flag_out(absent_flag_out));
module cfrbd_bench;
  logic mclk_in = 0, reset_in = 1, enable_n = 1, tfault = 0, done = 0;
  logic present = 1, high = 0, surge = 0;
  wire logic above, below, over;
  wire logic [8:0] outs;
  int num_errors = 0, num_checks = 0, cycles = 0, seed = 25;
  localparam int PWM = 8, PRB = 7, SNK = 6, WAK = 5, REM = 4, S1 = 3, S2 = 2, TF = 1, AB = 0;
  cfrbd_sequencer #(.SINK_CYC(32'h190), .WAKE_CYC(32'h190), .REMOVAL_CYC(32'h12c),
    .BLINK_CYC(32'h12c)) uut (.mclk_in(mclk_in), .reset_in(reset_in),
    .above_recharge_in(above), .below_short_in(below), .over_limit_in(over),
    .charge_enable_n_in(enable_n), .timer_fault_in(tfault), .charge_done_in(done),
    .pwm_enable_out(outs[PWM]), .probe_current_out(outs[PRB]),
    .absent_test_sink_out(outs[SNK]), .wake_current_out(outs[WAK]),
    .removal_sink_out(outs[REM]), .status_output_first_oe_n_out(outs[S1]),
    .status_output_second_oe_n_out(outs[S2]), .timer_fault_flag_out(outs[TF]),
    .absent_flag_out(outs[AB]));
  cfrbd_pack_model pack (.mclk_in(mclk_in), .present_in(present), .high_in(high),
    .surge_in(surge), .sink_in(outs[SNK] | outs[REM]), .wake_in(outs[WAK]),
    .above_recharge_out(above), .below_short_out(below), .over_limit_out(over));
  initial
    forever #2 mclk_in = ~mclk_in;
  // =====================================================================
  // checking and waiting
  // =====================================================================
  task automatic check(input string what, input logic seen, input logic exp);
    num_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %b seen %b", what, exp, seen);
    end
  endtask : check
  task automatic await(input int b, input logic lv);
    int n;
    n = 0;
    while (outs[b] !== lv && n < 3000)
    begin
      @(negedge mclk_in);
      n++;
    end
    check($sformatf("output %0d", b), outs[b], lv);
  endtask : await
  task automatic pause(input int n);
    repeat (n) @(negedge mclk_in);
  endtask : pause
  task automatic close_out;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out
  always @(posedge mclk_in)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      num_errors++;
      close_out();
    end
  end
  // =====================================================================
  // scenarios
  // =====================================================================
  initial
  begin
    pause(4);
    reset_in = 0;
    enable_n = 0;
    await(PWM, 1);
    check("status_output_first", outs[S1], 1'b0);
    repeat (3)
    begin
      surge = 1;
      pause(1 + ($unsigned($random(seed)) % 200));
      surge = 0;
      pause(20);
      check("pwm", outs[PWM], 1'b1);
    end
    enable_n = 1;
    await(PWM, 0);
    enable_n = 0;
    await(PWM, 1);
    $display("start done");
    tfault = 1;
    pause(1);
    tfault = 0;
    check("probe", outs[PRB], 1'b1);
    await(S1, 0);
    await(S1, 1);
    high = 1;
    await(PRB, 0);
    check("flag", outs[TF], 1'b1);
    high = 0;
    await(SNK, 1);
    check("flag", outs[TF], 1'b0);
    await(PWM, 1);
    $display("fault recovery done");
    tfault = 1;
    pause(1);
    tfault = 0;
    high = 1;
    pause(300);
    enable_n = 1;
    pause(300);
    enable_n = 0;
    await(TF, 0);
    high = 0;
    await(PWM, 1);
    $display("enable toggle done");
    tfault = 1;
    pause(1);
    tfault = 0;
    check("flag", outs[TF], 1'b1);
    reset_in = 1;
    pause(4);
    check("flag", outs[TF], 1'b0);
    reset_in = 0;
    await(PWM, 1);
    $display("power-on reset done");
    present = 0;
    await(REM, 1);
    check("pwm", outs[PWM], 1'b0);
    await(SNK, 1);
    await(WAK, 1);
    await(AB, 1);
    check("status_output_second", outs[S2], 1'b1);
    present = 1;
    await(PWM, 1);
    $display("absent test done");
    done = 1;
    pause(1);
    done = 0;
    check("status_output_second", outs[S2], 1'b0);
    await(SNK, 1);
    await(PWM, 1);
    surge = 1;
    high = 1;
    await(PWM, 0);
    check("status_output_first", outs[S1], 1'b1);
    surge = 0;
    pause(300);
    check("pwm", outs[PWM], 1'b0);
    high = 0;
    await(SNK, 1);
    await(PWM, 1);
    $display("overvoltage done");
    close_out();
  end
endmodule : cfrbd_bench

// *** sim/cfrbd_pack_model.sv ***
// removable pack model: fitted cell or bare output node
`timescale 1ns/1ns
module cfrbd_pack_model
(
  // clock
  input  wire logic mclk_in,
  // bench controls
  input  wire logic present_in,
  input  wire logic high_in,
  input  wire logic surge_in,
  // device currents
  input  wire logic sink_in,
  input  wire logic wake_in,
  // comparator pins
  output logic      above_recharge_out,
  output logic      below_short_out,
  output logic      over_limit_out
);
  logic bare_q = 1'b1;
  // bare node collapses under sink, rises under wake
  always_ff @(posedge mclk_in)
    if (sink_in)
      bare_q <= 1'b0;
    else if (wake_in)
      bare_q <= 1'b1;
  assign above_recharge_out = present_in ? high_in : bare_q;
  assign below_short_out    = present_in ? 1'b0 : !bare_q;
  assign over_limit_out     = surge_in;
endmodule : cfrbd_pack_model
